// ===== common/lsau_pkg.sv
package lsau_pkg;
   // Register map, word indices on the plain register port
   localparam logic [3:0] LSAU_REG_CTRL = 4'h0;
   localparam logic [3:0] LSAU_REG_STAT = 4'h1;
   localparam logic [3:0] LSAU_REG_BRT = 4'h2;
   localparam int unsigned CTRL_PRIV_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_ERR_BIT = 1;
   localparam logic CTRL_PRIV_RST = 1'b1;
   // Offset limits, magnitudes
   localparam logic [11:0] OFS_MAX_PLAIN = 12'hFFF;
   localparam logic [11:0] OFS_MAX_INDEX = 12'h0FF;
   localparam logic [11:0] OFS_MAX_NEG = 12'h0FF;
   localparam logic [11:0] OFS_MAX_PAIR = 12'h3FC;
   localparam logic [11:0] OFS_MAX_UNPRIV = 12'h0FF;
   localparam logic [31:0] PAIR_STEP = 32'h0000_0004;
   localparam logic [3:0] PC_IDX = 4'hF;

   typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_PAIR} lsau_size_e;
   typedef enum logic [2:0] {
      MD_OFFSET, MD_PRE, MD_POST, MD_REGOFS, MD_UNPRIV
   } lsau_mode_e;

   typedef struct packed {
      logic valid;
      logic load;
      lsau_size_e size;
      logic sext;
      lsau_mode_e mode;
      logic sub;
      logic has_imm;
      logic [11:0] imm;
      logic [1:0] shift;
      logic [31:0] base;
      logic [31:0] index;
      logic [31:0] data0;
      logic [31:0] data1;
      logic [3:0] transfer_reg;
      logic [3:0] second_transfer_reg;
   } lsau_req_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic unpriv;
      lsau_size_e size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } lsau_mem_s;

   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } lsau_rsp_s;

   typedef struct packed {
      logic done;
      logic err;
      logic xfer_we;
      logic [3:0] xfer_idx;
      logic [31:0] xfer_data;
      logic base_we;
      logic [31:0] base_data;
      logic branch;
      logic [31:0] target;
   } lsau_res_s;
endpackage

// ===== hdl/lsau_core.sv
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Offset mode: base plus/minus offset, base kept
// - Pre-index: adjusted address used and written back
// - Post-index: access at base, then base updated
// - Omitted offset: base itself is the address
// - Loads zero or sign extend bytes, halves
// - Single offsets -255..4095, indexed -255..255
// - Pair offsets multiple of 4, -1020..1020
// - Pair ops move two registers
// - Word load to PC branches, bit0 cleared
// - Flags never changed
// - Register offset: base plus index shifted 0..3
// - Unprivileged forms: offset 0..255 added only
// - Unprivileged forms always access unprivileged
module lsau_core (
   input wire logic ref_clk,
   input wire logic rst_n,
   input lsau_pkg::lsau_req_s req,
   output logic req_ready,
   output lsau_pkg::lsau_mem_s mem_req,
   input lsau_pkg::lsau_rsp_s mem_rsp,
   output lsau_pkg::lsau_res_s res,
   output logic flags_we,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   import lsau_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_ACC1, ST_ACC2} lsau_state_e;

   // Extend a right-justified load to a full word
   function automatic logic [31:0] lsau_ext(input logic [31:0] d,
      input lsau_size_e sz, input logic sx);
      logic [31:0] r;
      r = d;
      if (sz == SZ_BYTE) begin
         r = {{24{sx & d[7]}}, d[7:0]};
      end else if (sz == SZ_HALF) begin
         r = {{16{sx & d[15]}}, d[15:0]};
      end
      return r;
   endfunction

   // Check the offset against the form's legal range
   function automatic logic lsau_ofs_ok(input lsau_req_s q);
      logic ok;
      ok = 1'b1;
      if (q.mode == MD_UNPRIV) begin
         ok = !q.sub && q.imm <= OFS_MAX_UNPRIV;
      end else if (q.mode == MD_REGOFS) begin
         ok = q.size != SZ_PAIR;
      end else if (q.size == SZ_PAIR) begin
         ok = q.imm[1:0] == 2'b00 && q.imm <= OFS_MAX_PAIR;
      end else if (q.sub || q.mode != MD_OFFSET) begin
         ok = q.sub ? q.imm <= OFS_MAX_NEG : q.imm <= OFS_MAX_INDEX;
      end else begin
         ok = q.imm <= OFS_MAX_PLAIN;
      end
      if (!q.load && (q.sext || q.size == SZ_HALF && q.sext)) begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   lsau_state_e st_q, st_d;
   lsau_mem_s mem_q, mem_d;
   lsau_res_s res_q, res_d;
   lsau_req_s cur_q, cur_d;
   logic [31:0] wb_q, wb_d;
   logic ready_q, ready_d;
   logic priv_q, priv_d;
   logic err_q, err_d;
   logic [31:0] brt_q, brt_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] ofs, eff, ldv;
   logic take, ok;
   logic [31:0] cur_ofs;

   ////////////////////////////////////////////////////////////////////////
   // Address forming
   always_comb begin
      if (req.mode == MD_REGOFS) begin
         ofs = req.index << req.shift;
      end else begin
         ofs = req.has_imm ? {20'h0_0000, req.imm} : 32'h0000_0000;
      end
      // Register offsets always add
      eff = (req.sub && req.mode != MD_REGOFS) ? req.base - ofs
         : req.base + ofs;
      take = req.valid && ready_q;
      ok = lsau_ofs_ok(req);
      ldv = lsau_ext(mem_rsp.rdata, cur_q.size, cur_q.sext);
   end

   ////////////////////////////////////////////////////////////////////////
   // Access sequencer
   always_comb begin
      st_d = st_q;
      mem_d = mem_q;
      cur_d = cur_q;
      wb_d = wb_q;
      brt_d = brt_q;
      res_d = '0;
      case (st_q)
         ST_IDLE: begin
            if (take && !ok) begin
               res_d.err = 1'b1;
               res_d.done = 1'b1;
            end else if (take) begin
               cur_d = req;
               wb_d = eff;
               mem_d.valid = 1'b1;
               mem_d.write = !req.load;
               // Unprivileged forms drop privilege
               mem_d.unpriv = req.mode == MD_UNPRIV || !priv_q;
               mem_d.size = req.size == SZ_PAIR ? SZ_WORD : req.size;
               // Post-index accesses at the raw base
               mem_d.addr = req.mode == MD_POST ? req.base : eff;
               mem_d.wdata = req.data0;
               st_d = ST_ACC1;
            end
         end
         ST_ACC1, ST_ACC2: begin
            if (mem_rsp.valid) begin
               res_d.xfer_we = cur_q.load;
               res_d.xfer_idx = st_q == ST_ACC1 ? cur_q.transfer_reg
                  : cur_q.second_transfer_reg;
               res_d.xfer_data = ldv;
               if (cur_q.load && cur_q.size == SZ_WORD &&
                  cur_q.transfer_reg == PC_IDX) begin
                  res_d.xfer_we = 1'b0;
                  res_d.branch = 1'b1;
                  res_d.target = {mem_rsp.rdata[31:1], 1'b0};
                  brt_d = {mem_rsp.rdata[31:1], 1'b0};
               end
               if (st_q == ST_ACC1 && cur_q.size == SZ_PAIR) begin
                  // Second word follows the first
                  mem_d.addr = mem_q.addr + PAIR_STEP;
                  mem_d.wdata = cur_q.data1;
                  st_d = ST_ACC2;
               end else begin
                  mem_d.valid = 1'b0;
                  res_d.done = 1'b1;
                  // Only indexed forms write the base back
                  res_d.base_we = cur_q.mode == MD_PRE ||
                     cur_q.mode == MD_POST;
                  res_d.base_data = wb_q;
                  st_d = ST_IDLE;
               end
            end
         end
         default: begin
            st_d = ST_IDLE;
            mem_d = '0;
         end
      endcase
      ready_d = st_d == ST_IDLE;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         mem_q <= '0;
         res_q <= '0;
         cur_q <= '0;
         wb_q <= 32'h0000_0000;
         brt_q <= 32'h0000_0000;
         ready_q <= 1'b0;
      end else begin
         st_q <= st_d;
         mem_q <= mem_d;
         res_q <= res_d;
         cur_q <= cur_d;
         wb_q <= wb_d;
         brt_q <= brt_d;
         ready_q <= ready_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port
   always_comb begin
      priv_d = priv_q;
      err_d = err_q || res_q.err;
      rdata_d = 32'h0000_0000;
      if (reg_wr && reg_addr == LSAU_REG_CTRL) begin
         priv_d = reg_wdata[CTRL_PRIV_BIT];
      end
      // Write one clears; a new error wins
      if (reg_wr && reg_addr == LSAU_REG_STAT && reg_wdata[STAT_ERR_BIT]) begin
         err_d = res_q.err;
      end
      if (reg_rd) begin
         case (reg_addr)
            LSAU_REG_CTRL: rdata_d[CTRL_PRIV_BIT] = priv_q;
            LSAU_REG_STAT: begin
               rdata_d[STAT_BUSY_BIT] = st_q != ST_IDLE;
               rdata_d[STAT_ERR_BIT] = err_q;
            end
            LSAU_REG_BRT: rdata_d = brt_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         priv_q <= CTRL_PRIV_RST;
         err_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         flags_we <= 1'b0;
      end else begin
         priv_q <= priv_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
         flags_we <= 1'b0;
      end
   end

   assign req_ready = ready_q;
   assign mem_req = mem_q;
   assign res = res_q;
   assign reg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Offset of the request in flight, for the post-index writeback check
   assign cur_ofs = cur_q.has_imm ? {20'h0_0000, cur_q.imm} : 32'h0000_0000;

   sequence s_take_ok;
      take && ok;
   endsequence

   sequence s_first_pair;
      st_q == ST_ACC1 && mem_rsp.valid && cur_q.size == SZ_PAIR;
   endsequence

   a_offset_addr: assert property (
      s_take_ok ##0 req.mode == MD_OFFSET |=>
      mem_req.addr == ($past(req.sub) ? $past(req.base) - $past(ofs)
                                      : $past(req.base) + $past(ofs)))
      else $error("offset address wrong");
   a_offset_keep: assert property (
      res.done && cur_q.mode == MD_OFFSET |-> !res.base_we)
      else $error("offset mode wrote base");
   a_pre_wb: assert property (
      res.done && !res.err && cur_q.mode == MD_PRE |->
      res.base_we && res.base_data == mem_req.addr -
      (cur_q.size == SZ_PAIR ? PAIR_STEP : 32'h0000_0000))
      else $error("pre-index writeback missing");
   a_post_addr: assert property (
      s_take_ok ##0 req.mode == MD_POST |=>
      mem_req.valid && mem_req.addr == $past(req.base))
      else $error("post-index address not base");
   a_omit_ofs: assert property (
      s_take_ok ##0 req.mode != MD_REGOFS && !req.has_imm |=>
      mem_req.addr == $past(req.base))
      else $error("omitted offset changed address");
   a_sign_ext: assert property (
      res.xfer_we && $past(cur_q.size) == SZ_BYTE |->
      res.xfer_data[31:8] == {24{$past(cur_q.sext) & res.xfer_data[7]}})
      else $error("byte extension wrong");
   a_range_err: assert property (
      take && !ok |=> res.err && !mem_req.valid)
      else $error("illegal offset not refused");
   a_pair_step: assert property (
      s_first_pair |=> mem_req.valid &&
      mem_req.addr == $past(mem_req.addr) + PAIR_STEP)
      else $error("pair second address wrong");
   a_pc_branch: assert property (
      res.branch |-> res.target[0] == 1'b0 && !res.xfer_we)
      else $error("branch target bit0 set");
   a_flags_kept: assert property (!flags_we)
      else $error("flags written");
   a_unpriv_acc: assert property (
      mem_req.valid && cur_q.mode == MD_UNPRIV |-> mem_req.unpriv)
      else $error("unprivileged form accessed privileged");
   a_post_wb: assert property (
      res.done && !res.err && cur_q.mode == MD_POST |->
      res.base_we && res.base_data ==
         (cur_q.sub ? cur_q.base - cur_ofs : cur_q.base + cur_ofs))
      else $error("post-index writeback wrong");
   a_regofs_addr: assert property (
      s_take_ok ##0 req.mode == MD_REGOFS |=>
      mem_req.addr ==
      $past(req.base) + ($past(req.index) << $past(req.shift)))
      else $error("register offset address wrong");
   a_half_ext: assert property (
      res.xfer_we && cur_q.size == SZ_HALF |->
      res.xfer_data[31:16] == {16{cur_q.sext & res.xfer_data[15]}})
      else $error("halfword extension wrong");
   a_pair_second: assert property (
      res.done && !res.err && cur_q.load && cur_q.size == SZ_PAIR |->
      res.xfer_we && res.xfer_idx == cur_q.second_transfer_reg)
      else $error("pair second register missing");
endmodule

// ===== testbench/load_store_address_unit_tb_top.sv
`timescale 1ns/1ps
module load_store_address_unit_tb_top;
   import lsau_pkg::*;
   logic ref_clk, rst_n, req_ready, flags_we, reg_wr, reg_rd, slow;
   logic fin, got_err;
   lsau_req_s req;
   lsau_mem_s mem_req;
   lsau_rsp_s mem_rsp;
   lsau_res_s res;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [31:0] aq[$], dq[$], bq[$];
   logic uq[$];
   logic [3:0] iq[$];
   int err_count, samples_checked;
   lsau_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
      .req_ready(req_ready), .mem_req(mem_req), .mem_rsp(mem_rsp),
      .res(res), .flags_we(flags_we), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   lsau_mem_model mem (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
      .mem_req(mem_req), .mem_rsp(mem_rsp));
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Verdict
   task automatic stop_test();
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Record accesses and results
   always @(posedge ref_clk) begin
      if (mem_req.valid && mem_rsp.valid) begin
         aq.push_back(mem_req.addr);
         uq.push_back(mem_req.unpriv);
      end
      if (res.xfer_we) dq.push_back(res.xfer_data);
      if (res.xfer_we) iq.push_back(res.xfer_idx);
      if (res.branch) dq.push_back(res.target);
      if (res.base_we) bq.push_back(res.base_data);
      if (res.done) got_err = res.err;
      if (res.done) fin = 1'b1;
      if (rst_n) chk({31'h0, flags_we}, 32'h0);
   end
   // Distinct registers, no condition, word-only PC use
   // Legal register choices only
   function automatic lsau_req_s mk(logic ld, lsau_size_e sz,
         lsau_mode_e md, logic sub, logic [11:0] imm, logic [31:0] base);
      lsau_req_s r;
      r = '0;
      r.valid = 1'b1;
      r.load = ld;
      r.size = sz;
      r.mode = md;
      r.sub = sub;
      r.has_imm = 1'b1;
      r.imm = imm;
      r.base = base;
      r.transfer_reg = 4'h1;
      r.second_transfer_reg = 4'h2;
      return r;
   endfunction
   // One request, held one cycle once ready, then bounded wait for done
   task automatic go(input lsau_req_s r);
      int n;
      n = 0;
      aq = {};
      dq = {};
      bq = {};
      uq = {};
      iq = {};
      fin = 1'b0;
      while (req_ready !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (req_ready !== 1'b1) begin
         chk(32'h0, 32'h1);
         stop_test();
      end
      @(posedge ref_clk);
      req <= r;
      @(posedge ref_clk);
      req.valid <= 1'b0;
      while (fin !== 1'b1 && n < 80) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (fin !== 1'b1) begin
         chk(32'h0, 32'h1);
         stop_test();
      end
   endtask
   // Register port cycles
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // Offset store, then load at the negative limit
   task automatic t_offset();
      lsau_req_s r;
      r = mk(1'b0, SZ_WORD, MD_OFFSET, 1'b0, 12'h020, 32'h100);
      r.data0 = 32'h80F0;
      go(r);
      chk(aq[0], 32'h120);
      chk(bq.size(), 32'h0);
      chk({31'h0, uq[0]}, 32'h0);
      go(mk(1'b1, SZ_WORD, MD_OFFSET, 1'b1, 12'h0FF, 32'h21F));
      chk(aq[0], 32'h120);
      chk(dq[0], 32'h80F0);
   endtask
   // Narrow loads with omitted offset
   task automatic t_ext();
      lsau_req_s r;
      logic [31:0] e [4];
      e = '{32'hF0, 32'hFFFF_FFF0, 32'h80F0, 32'hFFFF_80F0};
      for (int i = 0; i < 4; i++) begin
         r = mk(1'b1, SZ_BYTE, MD_OFFSET, 1'b0, 12'h0, 32'h120);
         r.size = (i > 1) ? SZ_HALF : SZ_BYTE;
         r.sext = i[0];
         r.has_imm = 1'b0;
         go(r);
         chk(aq[0], 32'h120);
         chk(dq[0], e[i]);
      end
   endtask
   // Pre and post index, slow memory on the second
   task automatic t_index();
      go(mk(1'b1, SZ_WORD, MD_PRE, 1'b1, 12'h020, 32'h140));
      chk(aq[0], 32'h120);
      chk(bq[0], 32'h120);
      slow = 1'b1;
      go(mk(1'b0, SZ_HALF, MD_POST, 1'b0, 12'h0FF, 32'h130));
      chk(aq[0], 32'h130);
      chk(bq[0], 32'h22F);
      slow = 1'b0;
   endtask
   // Offsets out of range are refused without access
   task automatic t_bad();
      lsau_req_s r [5];
      r[0] = mk(1'b1, SZ_WORD, MD_OFFSET, 1'b1, 12'h100, 32'h200);
      r[1] = mk(1'b1, SZ_BYTE, MD_PRE, 1'b0, 12'h100, 32'h200);
      r[2] = mk(1'b0, SZ_PAIR, MD_POST, 1'b0, 12'h006, 32'h200);
      r[3] = mk(1'b1, SZ_PAIR, MD_OFFSET, 1'b0, 12'h400, 32'h200);
      r[4] = mk(1'b1, SZ_WORD, MD_UNPRIV, 1'b1, 12'h004, 32'h200);
      for (int i = 0; i < 5; i++) begin
         go(r[i]);
         chk({31'h0, got_err}, 32'h1);
         chk(aq.size(), 32'h0);
      end
      go(mk(1'b0, SZ_WORD, MD_OFFSET, 1'b0, 12'hFFF, 32'h0));
      chk({31'h0, got_err}, 32'h0);
      chk(aq[0], 32'hFFF);
   endtask
   // Pair store at the positive limit, pair load back
   task automatic t_pair();
      lsau_req_s r;
      r = mk(1'b0, SZ_PAIR, MD_PRE, 1'b0, 12'h3FC, 32'h200);
      r.data0 = 32'h1111_AAAA;
      r.data1 = 32'h2222_BBBB;
      go(r);
      chk(aq[0], 32'h5FC);
      chk(aq[1], 32'h600);
      chk(bq[0], 32'h5FC);
      go(mk(1'b1, SZ_PAIR, MD_POST, 1'b1, 12'h3FC, 32'h5FC));
      chk(aq[1], 32'h600);
      chk(dq[0], 32'h1111_AAAA);
      chk(dq[1], 32'h2222_BBBB);
      chk({28'h0, iq[0]}, 32'h1);
      chk({28'h0, iq[1]}, 32'h2);
      chk(bq[0], 32'h200);
   endtask
   // Index shifted by each amount
   task automatic t_regofs();
      lsau_req_s r;
      for (int s = 0; s < 4; s++) begin
         r = mk(1'b1, SZ_WORD, MD_REGOFS, 1'b0, 12'h0, 32'h100);
         r.index = 32'h8;
         r.shift = s[1:0];
         r.sub = s[0];
         go(r);
         chk(aq[0], 32'h100 + (32'h8 << s));
         chk(bq.size(), 32'h0);
      end
   endtask
   // Unprivileged access and program counter load
   task automatic t_misc();
      lsau_req_s r;
      go(mk(1'b1, SZ_WORD, MD_UNPRIV, 1'b0, 12'h0FF, 32'h21));
      chk(aq[0], 32'h120);
      chk({31'h0, uq[0]}, 32'h1);
      chk(bq.size(), 32'h0);
      r = mk(1'b0, SZ_WORD, MD_OFFSET, 1'b0, 12'h4, 32'h120);
      r.data0 = 32'h1235;
      go(r);
      r.load = 1'b1;
      r.transfer_reg = PC_IDX;
      go(r);
      chk(dq[0], 32'h1234);
      rd(LSAU_REG_BRT, 32'h1234);
      wr(LSAU_REG_CTRL, 32'h0);
      rd(LSAU_REG_CTRL, 32'h0);
      go(mk(1'b1, SZ_WORD, MD_OFFSET, 1'b0, 12'h0, 32'h120));
      chk({31'h0, uq[0]}, 32'h1);
      wr(LSAU_REG_CTRL, 32'h1);
   endtask
   // Main sequence
   initial begin
      rst_n = 1'b0;
      req = '0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      slow = 1'b0;
      err_count = 0;
      samples_checked = 0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      rd(LSAU_REG_CTRL, 32'h1);
      wr(4'hF, 32'hFFFF_FFFF);
      rd(4'hF, 32'h0);
      t_offset();
      t_ext();
      t_index();
      t_bad();
      rd(LSAU_REG_STAT, 32'h2);
      wr(LSAU_REG_STAT, 32'h2);
      rd(LSAU_REG_STAT, 32'h0);
      t_pair();
      t_regofs();
      t_misc();
      stop_test();
   end
endmodule

// ===== testbench/lsau_mem_model.sv
`timescale 1ns/1ps
// Memory behind the block: word array, answers in one or three cycles
module lsau_mem_model
   import lsau_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic slow,
   input lsau_pkg::lsau_mem_s mem_req,
   output lsau_pkg::lsau_rsp_s mem_rsp
);
   logic [31:0] mem_q [0:255];
   logic [1:0] wait_q;
   logic [31:0] idle_q;
   // One answer per held request; idle data keeps changing
   always_ff @(posedge ref_clk) begin
      idle_q <= ~idle_q;
      mem_rsp.valid <= 1'b0;
      mem_rsp.rdata <= idle_q;
      if (!rst_n) begin
         wait_q <= 2'h0;
         idle_q <= 32'h5A5A_A5A5;
      end else if (mem_req.valid && !mem_rsp.valid) begin
         wait_q <= wait_q + 2'h1;
         if (!slow || wait_q == 2'h2) begin
            wait_q <= 2'h0;
            mem_rsp.valid <= 1'b1;
            mem_rsp.rdata <= mem_q[mem_req.addr[9:2]] >>
               {mem_req.addr[1:0], 3'h0};
            // Narrow stores write the whole word
            if (mem_req.write) begin
               mem_q[mem_req.addr[9:2]] <= mem_req.wdata;
            end
         end
      end
   end
endmodule
